/* File: rtl/dtc_map.svh */
// register-free constants of the dual timer compare block
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_CNT_W      16
`define DTC_CMP_N      4
`define DTC_CLR_FREE   3'h0
`define DTC_CLR_CMP_A  3'h1
`define DTC_CLR_CMP_B  3'h2
`define DTC_CLR_CMP_C  3'h3
`define DTC_CLR_CMP_D  3'h4
`define DTC_DIV_DFLT   1
`define DTC_DIV_W      16
`endif

/* File: rtl/dtc_pkg.sv */
// shared types of the dual timer compare block
package dtc_pkg;
  typedef logic [2:0] dtc_clr_t;
  typedef logic [1:0] dtc_cmp_idx_t;
endpackage : dtc_pkg

/* File: rtl/dtc_ch_if.sv */
// link between the pair controller and one counter channel
`timescale 1ns/100ps
interface dtc_ch_if #(parameter int W = 16);
  logic                 tick;
  logic                 run;
  logic                 load;
  logic [W-1:0]         loadVal;
  dtc_pkg::dtc_clr_t    clrSel;
  logic                 cmpWr;
  dtc_pkg::dtc_cmp_idx_t cmpIdx;
  logic [W-1:0]         cmpData;
  logic [W-1:0]         count;
  logic [3:0]           match;
  logic                 ovf;
  modport chan (input tick, run, load, loadVal, clrSel, cmpWr, cmpIdx, cmpData,
                output count, match, ovf);
  modport ctrl (output tick, run, load, loadVal, clrSel, cmpWr, cmpIdx, cmpData,
                input count, match, ovf);
endinterface : dtc_ch_if

/* File: rtl/dtc_channel.sv */
// one 16-bit up-counter with four compare registers
`timescale 1ns/100ps
`include "dtc_map.svh"
module dtc_channel #(
  parameter int W = `DTC_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // controller side
  dtc_ch_if.chan   bus
);
  logic [W-1:0]            cnt_r;
  logic [W-1:0]            cnt_nxt;
  logic [3:0][W-1:0]       cmp_r;
  logic [3:0][W-1:0]       cmp_nxt;
  logic [3:0]              hit;
  logic                    clrHit;
  logic                    step;

  assign step = bus.tick & bus.run;

  genvar k;
  generate
    for (k = 0; k < `DTC_CMP_N; k++) begin : g_cmp
      assign hit[k] = step & (cnt_r == cmp_r[k]);
    end
  endgenerate

  always_comb begin
    case (bus.clrSel)
      `DTC_CLR_CMP_A: clrHit = hit[0];
      `DTC_CLR_CMP_B: clrHit = hit[1];
      `DTC_CLR_CMP_C: clrHit = hit[2];
      `DTC_CLR_CMP_D: clrHit = hit[3];
      default:        clrHit = 1'b0;
    endcase
  end

  always_comb begin
    cmp_nxt = cmp_r;
    if (bus.cmpWr) begin
      cmp_nxt[bus.cmpIdx] = bus.cmpData;
    end
    cnt_nxt = cnt_r;
    if (bus.load) begin
      cnt_nxt = bus.loadVal; // [R02] [R03]
    end else if (step) begin
      // clear only at the chosen compare, otherwise wrap freely
      cnt_nxt = clrHit ? '0 : cnt_r + 1'b1; // [R04]
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= '0;
      cmp_r <= '1; // all ones keeps an unset compare from hitting at zero
    end else begin
      cnt_r <= cnt_nxt;
      cmp_r <= cmp_nxt;
    end
  end

  assign bus.count = cnt_r; // [R01]
  assign bus.match = hit;
  assign bus.ovf   = step & ~bus.load & ~clrHit & (cnt_r == '1);
endmodule : dtc_channel

/* File: rtl/dtc_top.sv */
// pair of compare counters with lockstep write and conversion trigger
`timescale 1ns/100ps
`include "dtc_map.svh"
// Contract
// R01: reading a counter value port always shows its live count.
// R02: lockstep flag low: a counter write changes only the addressed counter.
// R03: lockstep flag high: a counter write loads the value into both counters.
// R04: software selects which compare match clears a counter to zero.
// R05: a counter may run as an internal timer with its pins undriven.
// R06: a compare match can serve as the conversion start trigger.
// R07: trigger select decides which matches start a conversion; others never do.
// R08: each compare match and each overflow raises an interrupt request.
// R09: a lockstep write lands in both counters in the same cycle.
module dtc_top #(
  parameter int W       = `DTC_CNT_W,
  parameter int CLK_DIV = `DTC_DIV_DFLT
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // counter write access
  input  wire logic             cntWrEn,
  input  wire logic             cntWrSel,
  input  wire logic [W-1:0]     cntWrData,
  input  wire logic             pairLockstepFlag,
  // compare register write access
  input  wire logic             cmpWrEn,
  input  wire logic             cmpWrSel,
  input  wire logic [1:0]       cmpWrIdx,
  input  wire logic [W-1:0]     cmpWrData,
  // mode control
  input  wire logic [1:0]       countRun,
  input  wire logic [2:0]       clearSel0,
  input  wire logic [2:0]       clearSel1,
  input  wire logic [7:0]       pinEnable,
  input  wire logic [7:0]       convTrigSel,
  // counter values
  output logic      [W-1:0]     firstCounterReg,
  output logic      [W-1:0]     secondCounterReg,
  // events
  output logic      [7:0]       compareIrq_r,
  output logic      [1:0]       overflowIrq_r,
  output logic                  convStart_r,
  // compare output pins
  output logic      [7:0]       cmpPin_r,
  output logic      [7:0]       cmpPinOe_r
);
  dtc_ch_if #(.W(W)) chBus [2] ();

  logic [`DTC_DIV_W-1:0] div_r;
  logic [`DTC_DIV_W-1:0] div_nxt;
  logic                  tick;
  logic [7:0]            allMatch;
  logic [1:0]            allOvf;
  logic [7:0]            compareIrq_nxt;
  logic [1:0]            overflowIrq_nxt;
  logic                  convStart_nxt;
  logic [7:0]            cmpPin_nxt;
  logic [7:0]            cmpPinOe_nxt;

  // count clock enable from the system clock divider
  assign tick = (div_r == '0);

  always_comb begin
    if (div_r == `DTC_DIV_W'(CLK_DIV - 1)) begin
      div_nxt = '0;
    end else begin
      div_nxt = div_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      assign chBus[c].tick    = tick;
      assign chBus[c].run     = countRun[c];
      // one write strobe feeds both loads, so lockstep writes share a cycle
      assign chBus[c].load    = cntWrEn & (pairLockstepFlag | (cntWrSel == 1'(c))); // [R09]
      assign chBus[c].loadVal = cntWrData;
      assign chBus[c].clrSel  = (c == 0) ? clearSel0 : clearSel1; // [R04]
      assign chBus[c].cmpWr   = cmpWrEn & (cmpWrSel == 1'(c));
      assign chBus[c].cmpIdx  = cmpWrIdx;
      assign chBus[c].cmpData = cmpWrData;
      assign allMatch[4*c +: 4] = chBus[c].match;
      assign allOvf[c]          = chBus[c].ovf;

      dtc_channel #(.W(W)) dtc_channel_inst (
        .clk    (clk),
        .resetn (resetn),
        .bus    (chBus[c])
      );
    end
  endgenerate

  assign firstCounterReg  = chBus[0].count; // [R01]
  assign secondCounterReg = chBus[1].count; // [R01]

  always_comb begin
    compareIrq_nxt  = allMatch; // [R08]
    overflowIrq_nxt = allOvf; // [R08]
    convStart_nxt   = |(allMatch & convTrigSel); // [R06] [R07]
    // a disabled pin stays low and undriven: internal timer use
    cmpPinOe_nxt    = pinEnable; // [R05]
    cmpPin_nxt      = (cmpPin_r ^ allMatch) & pinEnable; // [R05]
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      compareIrq_r  <= '0;
      overflowIrq_r <= '0;
      convStart_r   <= 1'b0;
      cmpPin_r      <= '0;
      cmpPinOe_r    <= '0;
    end else begin
      compareIrq_r  <= compareIrq_nxt;
      overflowIrq_r <= overflowIrq_nxt;
      convStart_r   <= convStart_nxt;
      cmpPin_r      <= cmpPin_nxt;
      cmpPinOe_r    <= cmpPinOe_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic wrSolo0;
  logic wrSolo1;
  logic wrPair;
  assign wrSolo0 = cntWrEn & ~pairLockstepFlag & ~cntWrSel;
  assign wrSolo1 = cntWrEn & ~pairLockstepFlag & cntWrSel;
  assign wrPair  = cntWrEn & pairLockstepFlag;

  property p_read_steps;
    (tick & countRun[0] & ~cntWrEn & (clearSel0 == `DTC_CLR_FREE))
      |=> firstCounterReg == W'($past(firstCounterReg) + 1'b1);
  endproperty
  a_read_steps: assert property (p_read_steps) else $error("count did not step"); // [R01]

  property p_solo_write;
    (wrSolo0 & ~countRun[1]) |=> (firstCounterReg == $past(cntWrData))
      && $stable(secondCounterReg);
  endproperty
  a_solo_write: assert property (p_solo_write) else $error("solo write leaked"); // [R02]

  property p_solo_write1;
    (wrSolo1 & ~countRun[0]) |=> (secondCounterReg == $past(cntWrData))
      && $stable(firstCounterReg);
  endproperty
  a_solo_write1: assert property (p_solo_write1) else $error("solo write leaked"); // [R02]

  property p_pair_write;
    wrPair |=> (firstCounterReg == $past(cntWrData)) && (secondCounterReg == $past(cntWrData));
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("pair write missed"); // [R03]

  property p_pair_aligned;
    (wrPair ##1 (~cntWrEn & (countRun == 2'h3) & (clearSel0 == `DTC_CLR_FREE)
      & (clearSel1 == `DTC_CLR_FREE)) [*2]) |-> firstCounterReg == secondCounterReg;
  endproperty
  a_pair_aligned: assert property (p_pair_aligned) else $error("pair drifted"); // [R09]

  property p_clear_at_cmp;
    (~cntWrEn & (clearSel0 == `DTC_CLR_CMP_A) & allMatch[0]) |=> firstCounterReg == '0;
  endproperty
  a_clear_at_cmp: assert property (p_clear_at_cmp) else $error("clear missed"); // [R04]

  // all eight pins: no level and no enable without the pin's enable bit
  property p_internal_only;
    ((cmpPinOe_r | cmpPin_r) & ~$past(pinEnable)) == 8'h00;
  endproperty
  a_internal_only: assert property (p_internal_only) else $error("pin driven"); // [R05]

  property p_trig_fire;
    (|(allMatch & convTrigSel)) |=> convStart_r;
  endproperty
  a_trig_fire: assert property (p_trig_fire) else $error("trigger lost"); // [R06]

  property p_trig_quiet;
    ((allMatch & convTrigSel) == '0) |=> !convStart_r;
  endproperty
  a_trig_quiet: assert property (p_trig_quiet) else $error("stray trigger"); // [R07]

  property p_ovf_irq;
    (tick & countRun[1] & ~cntWrEn & (secondCounterReg == '1)
      & (clearSel1 == `DTC_CLR_FREE)) |=> overflowIrq_r[1] && (secondCounterReg == '0);
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing"); // [R08]

  property p_cmp_irq;
    allMatch[5] |=> compareIrq_r[5];
  endproperty
  a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq missing"); // [R08]

  property p_cv_pair;
    wrPair ##1 (countRun == 2'h3) [*3];
  endproperty
  c_pair: cover property (p_cv_pair);

  property p_cv_trig;
    convStart_r ##1 convStart_r == 1'b0;
  endproperty
  c_trig: cover property (p_cv_trig);

  property p_cv_ovf;
    overflowIrq_r[0];
  endproperty
  c_ovf: cover property (p_cv_ovf);
endmodule : dtc_top

/* File: verification/dtc_top_bench.sv */
// self-checking bench for the dual compare counter pair
`timescale 1ns/100ps
module dtc_top_bench;
  logic        clk;
  logic        resetn;
  logic        cntWrEn;
  logic        cntWrSel;
  logic [15:0] cntWrData;
  logic        pairLockstepFlag;
  logic        cmpWrEn;
  logic        cmpWrSel;
  logic [1:0]  cmpWrIdx;
  logic [15:0] cmpWrData;
  logic [1:0]  countRun;
  logic [2:0]  clearSel0;
  logic [2:0]  clearSel1;
  logic [7:0]  pinEnable;
  logic [7:0]  convTrigSel;
  logic [15:0] firstCounterReg;
  logic [15:0] secondCounterReg;
  logic [7:0]  compareIrq_r;
  logic [1:0]  overflowIrq_r;
  logic        convStart_r;
  logic [7:0]  cmpPin_r;
  logic [7:0]  cmpPinOe_r;
  int          numErrors;
  int          comparisons;
  int          c;
  int          k;
  logic [7:0]  bitMask;

  dtc_top #(.W(16), .CLK_DIV(1)) dtc_top_inst (
    .clk(clk), .resetn(resetn), .cntWrEn(cntWrEn), .cntWrSel(cntWrSel),
    .cntWrData(cntWrData), .pairLockstepFlag(pairLockstepFlag), .cmpWrEn(cmpWrEn),
    .cmpWrSel(cmpWrSel), .cmpWrIdx(cmpWrIdx), .cmpWrData(cmpWrData), .countRun(countRun),
    .clearSel0(clearSel0), .clearSel1(clearSel1), .pinEnable(pinEnable),
    .convTrigSel(convTrigSel), .firstCounterReg(firstCounterReg),
    .secondCounterReg(secondCounterReg), .compareIrq_r(compareIrq_r),
    .overflowIrq_r(overflowIrq_r), .convStart_r(convStart_r), .cmpPin_r(cmpPin_r),
    .cmpPinOe_r(cmpPinOe_r)
  );

  always #10 clk = ~clk;

  // inputs always move 1 ns after the rising edge
  task tick();
    @(posedge clk);
    #1;
  endtask : tick

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // leading tick keeps a release and the next strobe in separate time steps
  task wrCnt(input logic sel, input logic [15:0] data);
    tick();
    cntWrEn   = 1'b1;
    cntWrSel  = sel;
    cntWrData = data;
    tick();
    cntWrEn   = 1'b0;
  endtask : wrCnt

  task wrCmp(input logic sel, input logic [1:0] idx, input logic [15:0] data);
    tick();
    cmpWrEn   = 1'b1;
    cmpWrSel  = sel;
    cmpWrIdx  = idx;
    cmpWrData = data;
    tick();
    cmpWrEn   = 1'b0;
  endtask : wrCmp

  task test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0; resetn = 1'b0; cntWrEn = 1'b0; cntWrSel = 1'b0; cntWrData = 16'h0000;
    pairLockstepFlag = 1'b0; cmpWrEn = 1'b0; cmpWrSel = 1'b0; cmpWrIdx = 2'h0;
    cmpWrData = 16'h0000; countRun = 2'h0; clearSel0 = 3'h0; clearSel1 = 3'h0;
    pinEnable = 8'h00; convTrigSel = 8'h00; numErrors = 0; comparisons = 0;
    repeat (16) tick();
    resetn = 1'b1;
    tick();
    check("first count", firstCounterReg, 16'h0000);
    check("second count", secondCounterReg, 16'h0000);
    check("events", 16'({compareIrq_r, cmpPinOe_r}), 16'h0000);
    $display("test reset done");
    wrCnt(1'b0, 16'h1234);
    check("first count", firstCounterReg, 16'h1234);
    check("second count", secondCounterReg, 16'h0000);
    wrCnt(1'b1, 16'hABCD);
    check("second count", secondCounterReg, 16'hABCD);
    check("first count", firstCounterReg, 16'h1234);
    $display("test independent write done");
    pairLockstepFlag = 1'b1;
    wrCnt(1'b1, 16'h0F0F);
    check("first count", firstCounterReg, 16'h0F0F);
    check("second count", secondCounterReg, 16'h0F0F);
    wrCnt(1'b0, 16'h2222);
    check("pair equal", 16'(firstCounterReg == secondCounterReg), 16'h0001);
    check("first count", firstCounterReg, 16'h2222);
    check("second count", secondCounterReg, 16'h2222);
    pairLockstepFlag = 1'b0;
    countRun = 2'h3;
    repeat (5) tick();
    check("first running", firstCounterReg, 16'h2227);
    check("second running", secondCounterReg, 16'h2227);
    countRun = 2'h0;
    $display("test lockstep write done");
    // one pass per compare; even passes forward to the converter, D drives its pin
    for (int i = 0; i < 8; i++) begin
      c = i / 4;
      k = i % 4;
      bitMask = 8'h01 << i;
      clearSel0 = (c == 0) ? 3'(k + 1) : 3'h0;
      clearSel1 = (c == 1) ? 3'(k + 1) : 3'h0;
      convTrigSel = (i % 2 == 0) ? bitMask : 8'h00;
      pinEnable = (k == 3) ? bitMask : 8'h00;
      wrCmp(c[0], k[1:0], 16'h0040 + 16'(i));
      wrCnt(c[0], 16'h0040 + 16'(i));
      countRun = 2'(1 << c);
      tick();
      check("match pulse", 16'(compareIrq_r), 16'(bitMask));
      check("conversion start", 16'(convStart_r), 16'(i % 2 == 0));
      check("cleared count", c ? secondCounterReg : firstCounterReg, 16'h0000);
      check("pin enable", 16'(cmpPinOe_r), 16'(pinEnable));
      check("pin level", 16'(cmpPin_r), 16'(pinEnable));
      tick();
      check("pulse end", 16'({compareIrq_r, 7'h00, convStart_r}), 16'h0000);
      check("count after clear", c ? secondCounterReg : firstCounterReg, 16'h0001);
      countRun = 2'h0;
    end
    $display("test compare events done");
    clearSel0 = 3'h0;
    wrCnt(1'b0, 16'hFFFF);
    countRun = 2'h1;
    tick();
    check("overflow pulse", 16'(overflowIrq_r), 16'h0001);
    check("wrapped count", firstCounterReg, 16'h0000);
    tick();
    check("overflow end", 16'(overflowIrq_r), 16'h0000);
    countRun = 2'h0;
    clearSel1 = 3'h0;
    wrCnt(1'b1, 16'hFFFF);
    countRun = 2'h2;
    tick();
    check("overflow pulse", 16'(overflowIrq_r), 16'h0002);
    check("wrapped count", secondCounterReg, 16'h0000);
    check("first held", firstCounterReg, 16'h0001);
    tick();
    check("overflow end", 16'(overflowIrq_r), 16'h0000);
    countRun = 2'h0;
    $display("test overflow done");
    test_done();
  end
endmodule : dtc_top_bench
